// ===== mcrb_params.svh
`ifndef MCRB_PARAMS_SVH
`define MCRB_PARAMS_SVH
`define MCRB_ADDR_WAKE     8'h09
`define MCRB_ADDR_PAGE     8'h0A
`define MCRB_ADDR_PDN      8'h0B
`define MCRB_ADDR_PUB      8'h0C
`define MCRB_ADDR_PUC      8'h0D
`define MCRB_ADDR_IEN      8'h0E
`define MCRB_ADDR_IFLG     8'h0F
`define MCRB_ADDR_DIR_A    8'h05
`define MCRB_ADDR_DIR_B    8'h06
`define MCRB_ADDR_DIR_C    8'h07
`define MCRB_IEN_MASK      8'h8D
`define MCRB_IFLG_MASK     8'h0D
`define MCRB_PAGE_MASK     8'h0C
`define MCRB_OPT_RESET     8'h3F
`define MCRB_OPT_MASK      8'h7F
`define MCRB_CTRL_RESET    8'hFF
`define MCRB_VECTOR        12'h008
`define MCRB_BIT_TMR       0
`define MCRB_BIT_EXT0      2
`define MCRB_BIT_EXT1      3
`define MCRB_BIT_GIE       7
`define MCRB_OPT_EDGE      6
`define MCRB_OPT_TCS       5
`define MCRB_OPT_TSE       4
`define MCRB_OPT_PSA       3
`endif

// ===== mcrb_pkg.sv
package mcrb_pkg;
    // Interrupt sequencing, Gray coded
    typedef enum logic [1:0] {
        MCRB_IDLE    = 2'b00,
        MCRB_SERVICE = 2'b01
    } mcrb_irq_state_type;
endpackage : mcrb_pkg

// ===== mcrb_edge_detect.sv
`timescale 1ns/100ps
// Sampled edge detector on a synchronous input
module mcrb_edge_detect (
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_level,
    input  wire logic i_rising,
    output logic      o_edge
);
    logic prev_q;

    // Track the pin through reset, so release never fakes an edge
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            prev_q <= i_level;
        end else begin
            prev_q <= i_level;
        end
    end

    assign o_edge = i_rising ? (i_level & ~prev_q) : (~i_level & prev_q);
endmodule : mcrb_edge_detect

// ===== mcrb_ctrl_reg.sv
`timescale 1ns/100ps
// Plain read/write control register with written-bit mask
module mcrb_ctrl_reg (
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_mask,
    input  wire logic [7:0] i_reset,
    output logic      [7:0] o_value
);
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_value <= i_reset;
        end else if (i_we) begin
            o_value <= i_wdata & i_mask;
        end
    end
endmodule : mcrb_ctrl_reg

// ===== mcu_control_register_bank.sv
`timescale 1ns/100ps
`include "mcrb_params.svh"
module mcu_control_register_bank (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [7:0]  i_addr,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    output logic             o_rhit,
    input  wire logic        i_acc_load,
    input  wire logic [7:0]  i_acc_data,
    output logic      [7:0]  o_acc,
    input  wire logic        i_option_load,
    input  wire logic        i_dir_load,
    input  wire logic        i_return_from_interrupt,
    input  wire logic        i_ext0_mode,
    input  wire logic        i_timer_overflow,
    input  wire logic        i_ext_irq_input_0,
    input  wire logic        i_ext_irq_input_1,
    input  wire logic [7:0]  i_port_b_pins,
    input  wire logic        i_sleeping,
    output logic             o_irq_take,
    output logic      [11:0] o_irq_vector,
    output logic             o_wake,
    output logic      [1:0]  o_page,
    output logic      [3:0]  o_port_a_pulldown_en,
    output logic      [3:0]  o_port_b_pulldown_en,
    output logic      [7:0]  o_port_b_pullup_en,
    output logic      [7:0]  o_port_c_pullup_en,
    output logic      [2:0]  o_prescaler_rate_field,
    output logic             o_prescaler_assign,
    output logic             o_timer_source_edge_select,
    output logic             o_timer_clock_source_select,
    output logic             o_ext0_edge_select,
    output logic      [8:0]  o_timer_div_log2,
    output logic      [7:0]  o_port_a_direction,
    output logic      [7:0]  o_port_b_direction,
    output logic      [7:0]  o_port_c_direction
);
    logic [7:0] wake_q;
    logic [7:0] page_q;
    logic [7:0] pdn_q;
    logic [7:0] pub_q;
    logic [7:0] puc_q;
    logic [7:0] ien_q;
    logic [7:0] ien_d;
    logic [7:0] iflg_q;
    logic [7:0] iflg_d;
    logic [7:0] acc_q;
    logic [7:0] opt_q;
    logic [7:0] dir_a_q;
    logic [7:0] dir_b_q;
    logic [7:0] dir_c_q;
    logic [7:0] pb_prev_q;
    mcrb_pkg::mcrb_irq_state_type state_q;
    mcrb_pkg::mcrb_irq_state_type state_d;

    // Address decode for the mapped special registers
    wire we_wake = i_wr && (i_addr == `MCRB_ADDR_WAKE);
    wire we_page = i_wr && (i_addr == `MCRB_ADDR_PAGE);
    wire we_pdn  = i_wr && (i_addr == `MCRB_ADDR_PDN);
    wire we_pub  = i_wr && (i_addr == `MCRB_ADDR_PUB);
    wire we_puc  = i_wr && (i_addr == `MCRB_ADDR_PUC);
    wire we_ien  = i_wr && (i_addr == `MCRB_ADDR_IEN);
    wire we_iflg = i_wr && (i_addr == `MCRB_ADDR_IFLG);
    wire dir_ok  = i_dir_load && (i_addr >= `MCRB_ADDR_DIR_A)
                   && (i_addr <= `MCRB_ADDR_DIR_C);

    // Shared write-mask register cells
    mcrb_ctrl_reg u_wake (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_we(we_wake),
        .i_wdata(i_wdata), .i_mask(`MCRB_CTRL_RESET), .i_reset(`MCRB_CTRL_RESET),
        .o_value(wake_q));
    mcrb_ctrl_reg u_pdn (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_we(we_pdn),
        .i_wdata(i_wdata), .i_mask(`MCRB_CTRL_RESET), .i_reset(`MCRB_CTRL_RESET),
        .o_value(pdn_q));
    mcrb_ctrl_reg u_pub (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_we(we_pub),
        .i_wdata(i_wdata), .i_mask(`MCRB_CTRL_RESET), .i_reset(`MCRB_CTRL_RESET),
        .o_value(pub_q));
    mcrb_ctrl_reg u_puc (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_we(we_puc),
        .i_wdata(i_wdata), .i_mask(`MCRB_CTRL_RESET), .i_reset(`MCRB_CTRL_RESET),
        .o_value(puc_q));
    mcrb_ctrl_reg u_dira (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_we(dir_ok && i_addr == `MCRB_ADDR_DIR_A), .i_wdata(acc_q),
        .i_mask(`MCRB_CTRL_RESET), .i_reset(`MCRB_CTRL_RESET), .o_value(dir_a_q));
    mcrb_ctrl_reg u_dirb (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_we(dir_ok && i_addr == `MCRB_ADDR_DIR_B), .i_wdata(acc_q),
        .i_mask(`MCRB_CTRL_RESET), .i_reset(`MCRB_CTRL_RESET), .o_value(dir_b_q));
    mcrb_ctrl_reg u_dirc (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_we(dir_ok && i_addr == `MCRB_ADDR_DIR_C), .i_wdata(acc_q),
        .i_mask(`MCRB_CTRL_RESET), .i_reset(`MCRB_CTRL_RESET), .o_value(dir_c_q));

    // Page buffer keeps only its page bits, so upper bits stay zero
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            page_q <= 8'h00;
        end else if (we_page) begin
            page_q <= i_wdata & `MCRB_PAGE_MASK;
        end
    end

    // Accumulator loads only from the core, never by address
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            acc_q <= 8'h00;
        end else if (i_acc_load) begin
            acc_q <= i_acc_data;
        end
    end

    // Option load copies the accumulator; bit 7 is dropped
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            opt_q <= `MCRB_OPT_RESET;
        end else if (i_option_load) begin
            opt_q <= acc_q & `MCRB_OPT_MASK;
        end
    end

    // External input edges; edge select picks the input 0 polarity
    logic ext0_edge;
    logic ext1_edge;
    mcrb_edge_detect u_ext0 (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_level(i_ext_irq_input_0), .i_rising(opt_q[`MCRB_OPT_EDGE]),
        .o_edge(ext0_edge));
    mcrb_edge_detect u_ext1 (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_level(i_ext_irq_input_1), .i_rising(1'b0),
        .o_edge(ext1_edge));

    // Flags: hardware set wins over a same-cycle software clear
    logic [7:0] flag_set;
    assign flag_set = {4'h0, ext1_edge, ext0_edge & i_ext0_mode, 1'b0, i_timer_overflow};
    always_comb begin
        iflg_d = we_iflg ? (i_wdata & `MCRB_IFLG_MASK) : iflg_q;
        iflg_d = (iflg_d | flag_set) & `MCRB_IFLG_MASK;
    end

    // Interrupt taken when global and source enables meet a new event
    logic [7:0] pend;
    assign pend       = flag_set & ien_q;
    assign o_irq_take = ien_q[`MCRB_BIT_GIE] && (|pend[3:0]);
    assign o_irq_vector = `MCRB_VECTOR;

    // Enable register; hardware clear on entry, set on return
    always_comb begin
        ien_d = we_ien ? (i_wdata & `MCRB_IEN_MASK) : ien_q;
        if (o_irq_take) begin
            ien_d[`MCRB_BIT_GIE] = 1'b0;
        end else if (i_return_from_interrupt) begin
            ien_d[`MCRB_BIT_GIE] = 1'b1;
        end
    end

    // Service tracking: idle until taken, back on return
    always_comb begin
        state_d = state_q;
        case (state_q)
            mcrb_pkg::MCRB_IDLE:    if (o_irq_take) state_d = mcrb_pkg::MCRB_SERVICE;
            mcrb_pkg::MCRB_SERVICE: if (i_return_from_interrupt) state_d = mcrb_pkg::MCRB_IDLE;
            default:                state_d = mcrb_pkg::MCRB_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ien_q     <= 8'h00;
            iflg_q    <= 8'h00;
            pb_prev_q <= 8'hFF;
            state_q   <= mcrb_pkg::MCRB_IDLE;
        end else begin
            ien_q     <= ien_d;
            iflg_q    <= iflg_d;
            pb_prev_q <= i_port_b_pins;
            state_q   <= state_d;
        end
    end

    // Wake on any enabled falling port B pin; pin 0 masked in interrupt use
    logic [7:0] wake_allow;
    assign wake_allow = ~wake_q & {7'h7F, ~i_ext0_mode};
    assign o_wake = i_sleeping && |(wake_allow & pb_prev_q & ~i_port_b_pins);

    // Read mux; flag reads show flags masked by enables
    always_comb begin
        o_rhit  = 1'b1;
        if (i_addr == `MCRB_ADDR_WAKE)      o_rdata = wake_q;
        else if (i_addr == `MCRB_ADDR_PAGE) o_rdata = page_q;
        else if (i_addr == `MCRB_ADDR_PDN)  o_rdata = pdn_q;
        else if (i_addr == `MCRB_ADDR_PUB)  o_rdata = pub_q;
        else if (i_addr == `MCRB_ADDR_PUC)  o_rdata = puc_q;
        else if (i_addr == `MCRB_ADDR_IEN)  o_rdata = ien_q;
        else if (i_addr == `MCRB_ADDR_IFLG) o_rdata = iflg_q & ien_q;
        else begin
            o_rdata = 8'h00;
            o_rhit  = 1'b0;
        end
    end

    // Pad and timer controls
    assign o_page                  = page_q[3:2];
    assign o_port_a_pulldown_en    = ~pdn_q[3:0];
    assign o_port_b_pulldown_en    = ~pdn_q[7:4];
    assign o_port_b_pullup_en      = ~pub_q;
    assign o_port_c_pullup_en      = ~puc_q;
    assign o_acc                   = acc_q;
    assign o_prescaler_rate_field  = opt_q[2:0];
    assign o_prescaler_assign      = opt_q[`MCRB_OPT_PSA];
    assign o_timer_source_edge_select  = opt_q[`MCRB_OPT_TSE];
    assign o_timer_clock_source_select = opt_q[`MCRB_OPT_TCS];
    assign o_ext0_edge_select      = opt_q[`MCRB_OPT_EDGE];
    // Log2 ratio: timer n+1, watchdog n (no prescaler effect on other)
    assign o_timer_div_log2 = opt_q[`MCRB_OPT_PSA] ? {6'h00, opt_q[2:0]}
                              : 9'(opt_q[2:0]) + 9'h001;
    assign o_port_a_direction      = dir_a_q;
    assign o_port_b_direction      = dir_b_q;
    assign o_port_c_direction      = dir_c_q;

    // Checks
    property p_gie_clear;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_irq_take |=> !ien_q[`MCRB_BIT_GIE];
    endproperty
    a_gie_clear: assert property (p_gie_clear) else $error("gie not cleared");
    property p_return_from_interrupt;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_return_from_interrupt && !o_irq_take) |=> ien_q[`MCRB_BIT_GIE];
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("gie not set");
    property p_no_take;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !ien_q[`MCRB_BIT_GIE] |-> !o_irq_take;
    endproperty
    a_no_take: assert property (p_no_take) else $error("take without gie");
    property p_tmr_flag;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_timer_overflow |=> iflg_q[`MCRB_BIT_TMR];
    endproperty
    a_tmr_flag: assert property (p_tmr_flag) else $error("timer flag lost");
    property p_ext1_flag;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ($fell(i_ext_irq_input_1)) |=> iflg_q[`MCRB_BIT_EXT1];
    endproperty
    a_ext1_flag: assert property (p_ext1_flag) else $error("ext1 flag lost");
    property p_flag_hold;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (iflg_q[`MCRB_BIT_EXT0] && !we_iflg) |=> iflg_q[`MCRB_BIT_EXT0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("ext0 flag dropped");
    property p_page_hi;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        we_page |=> page_q[7:4] == 4'h0;
    endproperty
    a_page_hi: assert property (p_page_hi) else $error("page high bits set");
    property p_opt_load;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_option_load |=> opt_q == ($past(acc_q) & `MCRB_OPT_MASK);
    endproperty
    a_opt_load: assert property (p_opt_load) else $error("option load wrong");
    property p_pin0_wake;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_ext0_mode && i_port_b_pins[7:1] == pb_prev_q[7:1]) |-> !o_wake;
    endproperty
    a_pin0_wake: assert property (p_pin0_wake) else $error("pin0 wake in irq mode");
    property p_service;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_irq_take |=> state_q == mcrb_pkg::MCRB_SERVICE;
    endproperty
    a_service: assert property (p_service) else $error("service not entered");
    property p_service_exit;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_return_from_interrupt && !o_irq_take) |=> state_q == mcrb_pkg::MCRB_IDLE;
    endproperty
    a_service_exit: assert property (p_service_exit) else $error("service not left");
    property p_dir_load;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_dir_load && i_addr == `MCRB_ADDR_DIR_B) |=> dir_b_q == $past(acc_q);
    endproperty
    a_dir_load: assert property (p_dir_load) else $error("direction load wrong");
    property p_ext0_flag;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (ext0_edge && i_ext0_mode) |=> iflg_q[`MCRB_BIT_EXT0];
    endproperty
    a_ext0_flag: assert property (p_ext0_flag) else $error("ext0 flag lost");
endmodule : mcu_control_register_bank

// ===== mcrb_core_model.sv
`timescale 1ns/100ps
// Core stand-in: issues one register access or special instruction at a time
module mcrb_core_model (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rhit,
    output logic      [7:0] o_addr,
    output logic            o_wr,
    output logic      [7:0] o_wdata,
    output logic            o_acc_load,
    output logic      [7:0] o_acc_data,
    output logic            o_option_load,
    output logic            o_dir_load,
    output logic            o_return_from_interrupt
);
    // Idle bus, all strobes low
    initial begin
        {o_addr, o_wdata, o_acc_data} = 24'h000000;
        {o_wr, o_acc_load, o_option_load, o_dir_load, o_return_from_interrupt} = 5'h00;
    end

    // Kind 0 write, 1 acc, 2 option, 3 direction, 4 return, 5 read
    // Released data is inverted so nothing stale can pass for a match
    task automatic op(input int k, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic hit);
        @(posedge i_ref_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_acc_data = d;
        o_wr = (k == 0);
        o_acc_load = (k == 1);
        o_option_load = (k == 2);
        o_dir_load = (k == 3);
        o_return_from_interrupt = (k == 4);
        @(posedge i_ref_clk);
        rd = i_rdata;
        hit = i_rhit;
        #1;
        {o_wr, o_acc_load, o_option_load, o_dir_load, o_return_from_interrupt} = 5'h00;
        o_addr = ~a;
        o_wdata = ~d;
        o_acc_data = ~d;
    endtask : op
endmodule : mcrb_core_model

// ===== mcu_control_register_bank_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module mcu_control_register_bank_tb;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] addr, wdata, rdata, acc_data, acc, pins, pub, puc, dira, dirb, dirc;
    logic wr, rhit, acc_load, option_load, dir_load, return_from_interrupt, irq_take, wake;
    logic ext0_mode = 1'b0, tmr_ovf = 1'b0, ext0 = 1'b1, ext1 = 1'b1, sleeping = 1'b0;
    logic [11:0] vec;
    logic [1:0] page;
    logic [3:0] pda, pdb;
    logic [2:0] rate;
    logic prescaler_assign, tse, tcs, edge_sel;
    logic [8:0] div;
    int n_fail = 0;
    int samples_checked = 0;

    initial pins = 8'hFF;
    always #4 i_ref_clk = ~i_ref_clk;

    mcu_control_register_bank i_mcu_control_register_bank (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wr(wr),
        .i_wdata(wdata), .o_rdata(rdata), .o_rhit(rhit), .i_acc_load(acc_load),
        .i_acc_data(acc_data), .o_acc(acc), .i_option_load(option_load),
        .i_dir_load(dir_load), .i_return_from_interrupt(return_from_interrupt), .i_ext0_mode(ext0_mode),
        .i_timer_overflow(tmr_ovf), .i_ext_irq_input_0(ext0), .i_ext_irq_input_1(ext1),
        .i_port_b_pins(pins), .i_sleeping(sleeping), .o_irq_take(irq_take),
        .o_irq_vector(vec), .o_wake(wake), .o_page(page), .o_port_a_pulldown_en(pda),
        .o_port_b_pulldown_en(pdb), .o_port_b_pullup_en(pub), .o_port_c_pullup_en(puc),
        .o_prescaler_rate_field(rate), .o_prescaler_assign(prescaler_assign),
        .o_timer_source_edge_select(tse), .o_timer_clock_source_select(tcs),
        .o_ext0_edge_select(edge_sel), .o_timer_div_log2(div),
        .o_port_a_direction(dira), .o_port_b_direction(dirb), .o_port_c_direction(dirc));

    mcrb_core_model i_mcrb_core_model (
        .i_ref_clk(i_ref_clk), .i_rdata(rdata), .i_rhit(rhit), .o_addr(addr), .o_wr(wr),
        .o_wdata(wdata), .o_acc_load(acc_load), .o_acc_data(acc_data),
        .o_option_load(option_load), .o_dir_load(dir_load), .o_return_from_interrupt(return_from_interrupt));

    // Inputs move just after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    task automatic cmd(input int k, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic h;
        i_mcrb_core_model.op(k, a, d, r, h);
    endtask : cmd

    // Data only compared where the address is mapped
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic eh);
        logic [7:0] r;
        logic h;
        i_mcrb_core_model.op(5, a, 8'h00, r, h);
        `CHK(h, eh)
        if (eh) `CHK(r, e)
    endtask : rd_chk

    // Wake is a one-cycle pulse, so look before each edge
    task automatic wake_chk(input logic [7:0] p, input logic e);
        logic seen;
        seen = 1'b0;
        pins = p;
        repeat (3) begin
            #3;
            seen = seen | (wake === 1'b1);
            @(posedge i_ref_clk);
            #1;
        end
        `CHK(seen, e)
    endtask : wake_chk

    task automatic test_reset;
        `CHK({edge_sel, tcs, tse, prescaler_assign, rate}, 7'h3F)
        `CHK({dira, dirb, dirc}, 24'hFFFFFF)
        `CHK({pub, puc, pda, pdb, page}, 26'h0000000)
        rd_chk(8'h09, 8'hFF, 1'b1);
        rd_chk(8'h0F, 8'h00, 1'b1);
        rd_chk(8'h08, 8'h00, 1'b0);
        rd_chk(8'h10, 8'h00, 1'b0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_regs;
        cmd(0, 8'h0A, 8'hFF);
        rd_chk(8'h0A, 8'h0C, 1'b1);
        `CHK(page, 2'h3)
        cmd(0, 8'h0B, 8'hA5);
        `CHK({pdb, pda}, 8'h5A)
        cmd(0, 8'h0C, 8'h3C);
        `CHK(pub, 8'hC3)
        cmd(0, 8'h0D, 8'h0F);
        `CHK(puc, 8'hF0)
        cmd(0, 8'h0E, 8'hFF);
        rd_chk(8'h0E, 8'h8D, 1'b1);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_opt_dir;
        cmd(1, 8'h00, 8'hDA);
        cmd(2, 8'h00, 8'h00);
        `CHK({edge_sel, tcs, tse, prescaler_assign, rate}, 7'h5A)
        `CHK(div, 9'h002)
        cmd(1, 8'h00, 8'h00);
        cmd(2, 8'h00, 8'h00);
        `CHK({edge_sel, tcs, tse, prescaler_assign, rate, div}, 16'h0001)
        for (int i = 0; i < 3; i++) begin
            cmd(1, 8'h00, 8'h11 << i);
            cmd(3, 8'h05 + i[7:0], 8'h00);
        end
        `CHK({dira, dirb, dirc, acc}, 32'h11224444)
        $display("test_opt_dir done");
    endtask : test_opt_dir

    task automatic test_irq;
        cmd(0, 8'h0E, 8'h85);
        tick(1);
        tmr_ovf = 1'b1;
        #3;
        `CHK({irq_take, vec}, 13'h1008)
        tick(1);
        tmr_ovf = 1'b0;
        rd_chk(8'h0E, 8'h05, 1'b1);
        rd_chk(8'h0F, 8'h01, 1'b1);
        cmd(4, 8'h00, 8'h00);
        rd_chk(8'h0E, 8'h85, 1'b1);
        cmd(0, 8'h0F, 8'h00);
        cmd(0, 8'h0E, 8'h05);
        tick(1);
        tmr_ovf = 1'b1;
        #3;
        `CHK(irq_take, 1'b0)
        tick(1);
        tmr_ovf = 1'b0;
        $display("test_irq done");
    endtask : test_irq

    task automatic test_ext;
        cmd(0, 8'h0F, 8'h00);
        cmd(0, 8'h0E, 8'h0C);
        ext0_mode = 1'b1;
        ext0 = 1'b0;
        ext1 = 1'b0;
        tick(3);
        rd_chk(8'h0F, 8'h0C, 1'b1);
        cmd(0, 8'h0F, 8'h00);
        cmd(1, 8'h00, 8'h40);
        cmd(2, 8'h00, 8'h00);
        ext0 = 1'b1;
        ext1 = 1'b1;
        tick(3);
        rd_chk(8'h0F, 8'h04, 1'b1);
        $display("test_ext done");
    endtask : test_ext

    task automatic test_wake;
        cmd(0, 8'h09, 8'hFE);
        ext0_mode = 1'b0;
        sleeping = 1'b1;
        wake_chk(8'hFD, 1'b0);
        wake_chk(8'hFC, 1'b1);
        wake_chk(8'hFF, 1'b0);
        ext0_mode = 1'b1;
        wake_chk(8'hFE, 1'b0);
        $display("test_wake done");
    endtask : test_wake

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // Main sequence after sixteen reset cycles
    initial begin
        tick(16);
        i_sys_rst = 1'b0;
        test_reset();
        test_regs();
        test_opt_dir();
        test_irq();
        test_ext();
        test_wake();
        // Mid-run reset must restore every register
        tick(1);
        i_sys_rst = 1'b1;
        tick(2);
        i_sys_rst = 1'b0;
        test_reset();
        report_and_stop();
    end

    // Whole run is about 120 cycles; cut off well past that
    initial begin
        #20000;
        n_fail++;
        report_and_stop();
    end
endmodule : mcu_control_register_bank_tb
